// File: hdl/bsq_channel.sv
// one switching channel: soft-start ramp, pre-bias hold, per-cycle pwm
`include "bsq_consts.svh"
module bsq_channel #(
    parameter int SS_CYCLES = `BSQ_SS_CYCLES,
    parameter int PERIOD = `BSQ_PERIOD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic current_mode,
    input wire logic tick,
    input wire bsq_pkg::bsq_chan_flags_t flags,
    output bsq_pkg::bsq_gate_t gate,
    output logic [`BSQ_REF_W-1:0] ref_level,
    output logic soft_start_done
);
    import bsq_pkg::*;

    // ramp arithmetic holds 32 bits, cycle phase holds 8 bits
    if (SS_CYCLES < 1 || SS_CYCLES >= (1 << 22) || PERIOD < 4 || PERIOD > 255) begin : g_bad
        $error("bsq_channel: bad parameters");
    end

    typedef struct packed {
        bsq_ch_state_t st;
        bsq_pwm_state_t pw;
        logic [23:0] ss_cnt;
        logic [`BSQ_REF_W-1:0] ref_lvl;
        logic ss_done;
        bsq_gate_t g;
        logic [7:0] ph;
    } bsq_ch_regs_t;

    bsq_ch_regs_t s_r;
    bsq_ch_regs_t s_nxt;
    logic off_cond;
    logic pre_tick;
    logic on_limit;

    // last cycle before a switching cycle start, and the latest on-time end
    assign pre_tick = (s_r.ph == 8'(PERIOD - 1));
    assign on_limit = (s_r.ph == 8'(PERIOD - 3));

    // off condition depends on the selected loop scheme
    always_comb begin
        if (current_mode) begin
            off_cond = flags.peak_reached;
        end else begin
            off_cond = flags.ripple_equal;
        end
    end

    // sequencing and pwm next state
    always_comb begin
        s_nxt = s_r;
        if (!run) begin
            s_nxt = '0;
        end else begin
            // reference ramp from zero over the soft-start time
            if (!s_r.ss_done) begin
                if (s_r.ss_cnt >= 24'(SS_CYCLES - 1)) begin
                    s_nxt.ss_done = 1'b1;
                    s_nxt.ref_lvl = '1;
                end else begin
                    s_nxt.ss_cnt = s_r.ss_cnt + 24'h1;
                    s_nxt.ref_lvl = `BSQ_REF_W'(({8'h0, s_r.ss_cnt} << `BSQ_REF_W) / SS_CYCLES);
                end
            end
            unique case (s_r.st)
                BSQ_CH_OFF: begin
                    s_nxt.st = BSQ_CH_WAIT;
                end
                BSQ_CH_WAIT: begin
                    // no gate at all: keeps a pre-biased output from discharging
                    if (flags.fb_above_ref) begin
                        s_nxt.st = BSQ_CH_RUN;
                    end
                end
                BSQ_CH_RUN: begin
                end
                default: s_nxt.st = BSQ_CH_OFF;
            endcase
            unique case (s_r.pw)
                BSQ_HS_IDLE: begin
                    if (s_r.st == BSQ_CH_RUN && tick) begin
                        s_nxt.pw = BSQ_HS_ON;
                    end
                end
                BSQ_HS_ON: begin
                    // forced end leaves room for dead, low and gap before next start
                    if (off_cond || on_limit) begin
                        s_nxt.pw = BSQ_HS_DEAD;
                    end
                end
                BSQ_HS_DEAD: begin
                    s_nxt.pw = BSQ_HS_LOW;
                end
                BSQ_HS_LOW: begin
                    // one gap cycle, then high side again at the very next start
                    if (pre_tick) begin
                        s_nxt.pw = BSQ_HS_IDLE;
                    end
                end
            endcase
            s_nxt.g.high_side_gate_drive = (s_nxt.pw == BSQ_HS_ON);
            s_nxt.g.low_side_gate_drive = (s_nxt.pw == BSQ_HS_LOW);
        end
        // cycle phase tracks the shared divider even while the channel is off
        s_nxt.ph = tick ? 8'h1 : s_r.ph + 8'h1;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gate = s_r.g;
    assign ref_level = s_r.ref_lvl;
    assign soft_start_done = s_r.ss_done;
endmodule

// File: hdl/bsq_consts.svh
// constants for the buck enable, switch-over and pwm sequencer
`ifndef BSQ_CONSTS_SVH
`define BSQ_CONSTS_SVH

`define BSQ_CLK_HZ 25000000
`define BSQ_SS_TIME_NS 960000
`define BSQ_SWO_DELAY_NS 7700000
`define BSQ_SS_CYCLES ((`BSQ_SS_TIME_NS / 1000) * (`BSQ_CLK_HZ / 1000000))
`define BSQ_SWO_CYCLES ((`BSQ_SWO_DELAY_NS / 1000) * (`BSQ_CLK_HZ / 1000000))
`define BSQ_PERIOD_CYCLES 100
`define BSQ_REF_W 10
`define BSQ_SEL_GND 2'h0
`define BSQ_SEL_REF2 2'h1
`define BSQ_SEL_3V3 2'h2
`define BSQ_SEL_5V 2'h3

`endif

// File: hdl/bsq_pkg.sv
// types shared by the sequencer modules
package bsq_pkg;
    typedef enum logic [1:0] {
        BSQ_CH_OFF = 2'h0,
        BSQ_CH_WAIT = 2'h1,
        BSQ_CH_RUN = 2'h3
    } bsq_ch_state_t;

    typedef enum logic [1:0] {
        BSQ_HS_IDLE = 2'h0,
        BSQ_HS_ON = 2'h1,
        BSQ_HS_DEAD = 2'h3,
        BSQ_HS_LOW = 2'h2
    } bsq_pwm_state_t;

    // analog comparator flags of one channel
    typedef struct packed {
        logic fb_above_ref;
        logic peak_reached;
        logic ripple_equal;
    } bsq_chan_flags_t;

    // gate drive pair of one channel
    typedef struct packed {
        logic high_side_gate_drive;
        logic low_side_gate_drive;
    } bsq_gate_t;
endpackage

// File: hdl/bsq_top.sv
// top: enable states, rail control, 5 v switch-over, two pwm channels
`include "bsq_consts.svh"
module bsq_top #(
    parameter int SS_CYCLES = `BSQ_SS_CYCLES,
    parameter int SWO_CYCLES = `BSQ_SWO_CYCLES,
    parameter int PERIOD = `BSQ_PERIOD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic master_enable,
    input wire logic [1:0] channel_enable_n,
    input wire logic [1:0] control_scheme_select,
    input wire logic [1:0] light_load_select,
    input wire logic channel_one_power_good,
    input wire logic aux_five_volt_input,
    input wire bsq_pkg::bsq_chan_flags_t [1:0] chan_flags,
    output logic always_on_3v3_rail,
    output logic two_volt_reference,
    output logic five_volt_rail,
    output logic switchover_closed,
    output logic ovp_enable,
    output logic current_mode,
    output bsq_pkg::bsq_gate_t [1:0] gate,
    output logic [1:0] soft_start_done
);
    import bsq_pkg::*;

    // counters are 24 bits for the switch-over delay and 8 bits for the divider
    if (SWO_CYCLES < 1 || SWO_CYCLES >= (1 << 24) || PERIOD < 4 || PERIOD > 255
        || SS_CYCLES < 1) begin : g_bad
        $error("bsq_top: bad parameters");
    end

    typedef struct packed {
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        bsq_chan_flags_t [1:0] fl_a;
        bsq_chan_flags_t [1:0] fl_b;
        logic [23:0] swo_cnt;
        logic swo;
        logic [7:0] per_cnt;
        logic ref2;
        logic rail5;
        logic ovp;
        logic cmode;
    } bsq_top_regs_t;

    bsq_top_regs_t s_r;
    bsq_top_regs_t s_nxt;
    logic [1:0] run;
    logic tick;
    logic [1:0] ss_done_w;
    bsq_gate_t [1:0] gate_w;
    logic swo_qual;

    // light-load selection is accepted but deliberately not used at start-up
    logic unused_ll;
    assign unused_ll = ^light_load_select;

    assign tick = (s_r.per_cnt == 8'h0);
    assign swo_qual = channel_enable_n[0] && master_enable && s_r.sync_b[0] && s_r.sync_b[1];

    // global next state
    always_comb begin
        s_nxt = s_r;
        // two-flop synchronisers for analog flags
        s_nxt.sync_a = {aux_five_volt_input, channel_one_power_good};
        s_nxt.sync_b = s_r.sync_a;
        s_nxt.fl_a = chan_flags;
        s_nxt.fl_b = s_r.fl_a;
        // switching clock divider
        if (s_r.per_cnt >= 8'(PERIOD - 1)) begin
            s_nxt.per_cnt = 8'h0;
        end else begin
            s_nxt.per_cnt = s_r.per_cnt + 8'h1;
        end
        // two-volt reference follows master enable
        s_nxt.ref2 = master_enable;
        // switch-over qualify delay, instant release
        if (!swo_qual) begin
            s_nxt.swo = 1'b0;
            s_nxt.swo_cnt = 24'h0;
        end else if (!s_r.swo) begin
            if (s_r.swo_cnt >= 24'(SWO_CYCLES - 1)) begin
                s_nxt.swo = 1'b1;
            end else begin
                s_nxt.swo_cnt = s_r.swo_cnt + 24'h1;
            end
        end
        s_nxt.rail5 = master_enable && !s_nxt.swo;
        // loop scheme decode
        unique case (control_scheme_select)
            `BSQ_SEL_GND: begin
                s_nxt.cmode = 1'b1;
                s_nxt.ovp = 1'b1;
            end
            `BSQ_SEL_REF2: begin
                s_nxt.cmode = 1'b0;
                s_nxt.ovp = 1'b0;
            end
            `BSQ_SEL_3V3: begin
                s_nxt.cmode = 1'b0;
                s_nxt.ovp = 1'b1;
            end
            `BSQ_SEL_5V: begin
                s_nxt.cmode = 1'b1;
                s_nxt.ovp = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // one channel per enable
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            assign run[i] = master_enable && channel_enable_n[i];
            bsq_channel #(
                .SS_CYCLES(SS_CYCLES),
                .PERIOD(PERIOD)
            ) u_ch (
                .sys_clk(sys_clk),
                .rst(rst),
                .run(run[i]),
                .current_mode(s_r.cmode),
                .tick(tick),
                .flags(s_r.fl_b[i]),
                .gate(gate_w[i]),
                .ref_level(),
                .soft_start_done(ss_done_w[i])
            );
        end
    endgenerate

    // outputs
    assign always_on_3v3_rail = 1'b1;
    assign two_volt_reference = s_r.ref2;
    assign five_volt_rail = s_r.rail5;
    assign switchover_closed = s_r.swo;
    assign ovp_enable = s_r.ovp;
    assign current_mode = s_r.cmode;
    assign gate = gate_w;
    assign soft_start_done = ss_done_w;
endmodule

// File: test/bsq_stage.sv
// power stage and comparator model for both channels
module bsq_stage (
    input wire logic sys_clk,
    input wire logic [1:0] fb_ok,
    input wire logic use_peak,
    input wire bsq_pkg::bsq_gate_t [1:0] gate,
    output bsq_pkg::bsq_chan_flags_t [1:0] flags
);
    import bsq_pkg::*;
    logic [1:0] hs_r;
    // comparators trip two cycles after high side on, drop two cycles after it goes off
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            hs_r[i] <= gate[i].high_side_gate_drive;
            flags[i].fb_above_ref <= fb_ok[i];
            flags[i].peak_reached <= use_peak && hs_r[i];
            flags[i].ripple_equal <= !use_peak && hs_r[i];
        end
    end
endmodule

// File: test/bsq_top_chk.sv
// assertions on the sequencer top ports
`include "bsq_consts.svh"
module bsq_chk #(
    parameter int SWO_CYCLES = `BSQ_SWO_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic master_enable,
    input wire logic [1:0] channel_enable_n,
    input wire logic [1:0] control_scheme_select,
    input wire logic channel_one_power_good,
    input wire logic aux_five_volt_input,
    input wire logic always_on_3v3_rail,
    input wire logic two_volt_reference,
    input wire logic five_volt_rail,
    input wire logic switchover_closed,
    input wire logic ovp_enable,
    input wire logic current_mode,
    input wire bsq_pkg::bsq_gate_t [1:0] gate
);
    import bsq_pkg::*;
    int qual_r;
    // consecutive cycles with switch-over qualified
    always_ff @(posedge sys_clk) begin
        qual_r <= (rst || !(master_enable && channel_enable_n[0] && channel_one_power_good
            && aux_five_volt_input)) ? 0 : qual_r + 1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_aon; always_on_3v3_rail; endproperty
    a_aon: assert property (p_aon) else $error("rail dropped");
    property p_off; !master_enable |=> !two_volt_reference && !five_volt_rail; endproperty
    a_off: assert property (p_off) else $error("rails on in shutdown");
    property p_stby; master_enable |=> two_volt_reference; endproperty
    a_stby: assert property (p_stby) else $error("reference off");
    property p_mode; 1 |=> current_mode == ~^$past(control_scheme_select); endproperty
    a_mode: assert property (p_mode) else $error("loop mode wrong");
    property p_ovp; 1 |=> ovp_enable == !$past(control_scheme_select[0]); endproperty
    a_ovp: assert property (p_ovp) else $error("ovp decode wrong");
    property p_bbm; !(gate[0].high_side_gate_drive && gate[0].low_side_gate_drive)
        && !(gate[1].high_side_gate_drive && gate[1].low_side_gate_drive); endproperty
    a_bbm: assert property (p_bbm) else $error("gate overlap");
    property p_choff; !(master_enable && channel_enable_n[0])
        |-> ##2 !gate[0].high_side_gate_drive; endproperty
    a_choff: assert property (p_choff) else $error("channel runs disabled");
    property p_swmin; $rose(switchover_closed) |-> $past(qual_r) >= SWO_CYCLES; endproperty
    a_swmin: assert property (p_swmin) else $error("switch-over early");
    property p_swmax; qual_r == SWO_CYCLES + 8 |-> switchover_closed; endproperty
    a_swmax: assert property (p_swmax) else $error("switch-over late");
    property p_swrel; !channel_enable_n[0] |=> !switchover_closed; endproperty
    a_swrel: assert property (p_swrel) else $error("switch stays closed");
    property p_back; $fell(switchover_closed) && master_enable
        |-> ##[0:1] five_volt_rail; endproperty
    a_back: assert property (p_back) else $error("regulator not back");
endmodule
bind bsq_top bsq_chk #(.SWO_CYCLES(SWO_CYCLES)) chk_u (.sys_clk, .rst, .master_enable,
    .channel_enable_n, .control_scheme_select, .channel_one_power_good,
    .aux_five_volt_input, .always_on_3v3_rail, .two_volt_reference, .five_volt_rail,
    .switchover_closed, .ovp_enable, .current_mode, .gate);

// File: test/test_bsq_top.sv
// self-checking bench for the sequencer top
module test_bsq_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bsq_pkg::*;
    localparam int SWO = 50;
    localparam int PER = 20;
    // rows: master, select, then ref, five, current mode, ovp
    localparam logic [6:0] ROWS [6] = '{7'h03, 7'h10, 7'h4f, 7'h5c, 7'h6d, 7'h7e};
    localparam logic [3:0] DROP [3] = '{4'h5, 4'h9, 4'hc};
    logic sys_clk = 0, rst = 1, master_enable = 1, channel_one_power_good = 0;
    logic aux_five_volt_input = 0, use_peak = 1;
    logic [1:0] channel_enable_n = 0, control_scheme_select = 0, light_load_select = 0;
    logic [1:0] fb_ok = 0, soft_start_done;
    logic always_on_3v3_rail, two_volt_reference, five_volt_rail, switchover_closed;
    logic ovp_enable, current_mode;
    bsq_chan_flags_t [1:0] chan_flags;
    bsq_gate_t [1:0] gate;
    int failures = 0, check_count = 0, n, w, h0, h1;
    bsq_top #(.SS_CYCLES(20), .SWO_CYCLES(SWO), .PERIOD(PER)) dut_u (.sys_clk, .rst,
        .master_enable, .channel_enable_n, .control_scheme_select, .light_load_select,
        .channel_one_power_good, .aux_five_volt_input, .chan_flags, .always_on_3v3_rail,
        .two_volt_reference, .five_volt_rail, .switchover_closed, .ovp_enable,
        .current_mode, .gate, .soft_start_done);
    bsq_stage stage_u (.sys_clk, .fb_ok, .use_peak, .gate, .flags(chan_flags));
    // 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // wait for channel one high side to reach a level, w counts cycles
    task automatic wait_hs(input logic lvl, input int lim);
        w = 0;
        while (gate[0].high_side_gate_drive !== lvl) begin
            cyc(1);
            w++;
            if (w > lim) begin
                failures++;
                $display("ERROR %0t gate edge missing", $time);
                end_of_test();
            end
        end
    endtask
    // count high side cycles of both channels
    task automatic watch(input int k);
        h0 = 0;
        h1 = 0;
        repeat (k) begin
            cyc(1);
            if (gate[0].high_side_gate_drive !== 1'b0) h0++;
            if (gate[1].high_side_gate_drive !== 1'b0) h1++;
        end
    endtask
    // main sequence
    initial begin
        cyc(12);
        chk({always_on_3v3_rail, two_volt_reference, five_volt_rail, switchover_closed},
            4'h8, "reset values");
        rst = 0;
        foreach (ROWS[i]) begin
            {master_enable, control_scheme_select} = ROWS[i][6:4];
            light_load_select = ROWS[i][5:4];
            cyc(3);
            chk({two_volt_reference, five_volt_rail, current_mode, ovp_enable},
                ROWS[i][3:0], "rail or mode");
            $display("row %0d done", i);
        end
        channel_enable_n = 2'h3;
        watch(40);
        chk(h0 + h1 > 0, 0, "drive before feedback");
        fb_ok = 2'h3;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                control_scheme_select = s[1:0];
                light_load_select = s[1:0];
                use_peak = p[0];
                cyc(2 * PER);
                wait_hs(0, 2 * PER);
                wait_hs(1, PER + 2);
                wait_hs(0, PER + 2);
                chk(w < PER / 2, (~^s[1:0]) == p[0], "on-time");
                cyc(1);
                chk(gate[0].low_side_gate_drive, 1, "low side");
            end
            $display("mode %0d done", s);
        end
        chk(soft_start_done, 2'h3, "ramp done");
        channel_enable_n = 2'h2;
        cyc(2);
        watch(2 * PER);
        chk({h0 == 0, h1 > 0}, 2'h3, "channel enables");
        for (int c = 0; c < 3; c++) begin
            {aux_five_volt_input, channel_one_power_good, channel_enable_n} = 4'hd;
            n = 0;
            while (switchover_closed !== 1'b1 && n < SWO + 20) begin
                cyc(1);
                n++;
            end
            cyc(2);
            chk({n >= SWO && n < SWO + 10, five_volt_rail}, 2'h2, "switch-over");
            if (n >= SWO + 20) end_of_test();
            {aux_five_volt_input, channel_one_power_good, channel_enable_n} = DROP[c];
            cyc(5);
            chk({switchover_closed, five_volt_rail}, 2'h1, "switch release");
            $display("release %0d done", c);
        end
        master_enable = 0;
        channel_enable_n = 2'h3;
        cyc(2);
        watch(2 * PER);
        chk(h0 + h1 > 0, 0, "shutdown drive");
        end_of_test();
    end
endmodule
